// ==== src/prsm_defines.vh ====
// Constants for the partial reconfiguration status monitor
// Functional notes
// R1: 32-bit status output, low byte meaningful
// R2: Bit 7 low after configuration error
// R3: Bit 6 high once sync word received
// R4: Bit 5 high during readback
// R5: Bit 4 low while abort in progress
// R6: Upper nibble 9, D, 5, 1 encodings
// R7: Low nibble F or B by family
// R8: Idle 0x9F, 0xDF after sync word
// R9: CRC error shows 0x5F one cycle, then 0x1F
// R10: CRC error pulls init status pin low
// R11: Reset-CRC command clears error, releases pin
// R12: Reload: 0x1F to 0x5F to 0xDF
// R13: Release command without error returns 0x9F
// R14: Partial-done output mirrors done pin; held low for one cycle after each frame completes
// R15: Controller uses end-of-startup across slices
// R16: Partial-error output mirrors init status pin
// R17: Controller latches partial-error pulse itself
// R18: Controller recovers via status bits, reloading
// R19: Configuration memory accessed in whole frames
// R20: Done pin high after initial load
// R21: Status register bit 0 flags CRC failure
// R22: Controller never asserts program/init pins
// R23: Controller keeps sticky error until retry
`ifndef PRSM_DEFINES_VH
`define PRSM_DEFINES_VH
`define PRSM_ADR_CTRL      4'h0
`define PRSM_ADR_CMD       4'h1
`define PRSM_ADR_STAT      4'h2
`define PRSM_ADR_PORT      4'h3
`define PRSM_ADR_FRAMES    4'h4
`define PRSM_CTRL_NEWFAM   0
`define PRSM_CTRL_READBACK 1
`define PRSM_CTRL_ABORT    2
`define PRSM_CMD_SYNC      0
`define PRSM_CMD_CRC_ERR   1
`define PRSM_CMD_RESET_CRC_COMMAND      2
`define PRSM_CMD_RELEASE   3
`define PRSM_CMD_FULLDONE  4
`define PRSM_CMD_FRAME     5
`define PRSM_CMD_SEG_END   6
`define PRSM_LOW_OLD       4'hF
`define PRSM_LOW_NEW       4'hB
`define PRSM_HI_IDLE       4'h9
`define PRSM_HI_SYNC       4'hD
`define PRSM_HI_SYNC_ERR   4'h5
`define PRSM_HI_ERR        4'h1
`define PRSM_FRAME_WORDS   8'h5D
`endif

// ==== src/prsm_sync2.v ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module prsm_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  // First stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      q_o      <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== src/prsm_frame_cnt.v ====
// Whole-frame word counter for configuration memory access
`timescale 1ns/1ps
`default_nettype none
module prsm_frame_cnt #(
  parameter WORDS = 8'h5D
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        word_i,
  input  wire        abort_i,
  output reg         frame_done_o,
  output reg  [15:0] frames_o
);
  reg [7:0] cnt_reg;
  // Frame commits only after its last word; partial frames discarded
  always @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      cnt_reg      <= 8'h00;
      frame_done_o <= 1'b0;
      if (rst_i)
        frames_o <= 16'h0000;
    end else begin
      frame_done_o <= 1'b0;
      if (word_i) begin
        if (cnt_reg == WORDS - 8'h01) begin // [R19]
          cnt_reg      <= 8'h00;
          frame_done_o <= 1'b1;
          frames_o     <= frames_o + 16'h0001;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/prsm_top.v ====
// Configuration port status monitor with Wishbone register access
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "prsm_defines.vh"
module prsm_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        ext_done_i,
  output reg  [31:0] status_o,
  output reg         init_status_n_o,
  output reg         init_status_oe_n_o,
  output reg         done_o,
  output reg         done_oe_n_o,
  output reg         partial_done_echo_o,
  output reg         partial_error_echo_o,
  output reg         crc_error_o
);
  ////////////////////////////////////////////////////////////////////
  // State encoding, one-hot
  localparam [4:0] ST_IDLE   = 5'b00001;
  localparam [4:0] ST_SYNC   = 5'b00010;
  localparam [4:0] ST_ERR1   = 5'b00100;
  localparam [4:0] ST_ERR    = 5'b01000;
  localparam [4:0] ST_RELOAD = 5'b10000;

  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  wire        sync_next;
  wire        err_next;
  reg         sync_aligned_reg;
  reg         cfg_err_reg;
  reg         pulse_reg;
  reg         new_family_reg;
  reg         readback_active_reg;
  reg         abort_reg;
  reg         full_done_reg;
  reg         seg_err_reg;
  reg  [6:0]  cmd_reg;
  wire        ext_done_s;
  wire        frame_done;
  wire [15:0] frames;
  wire        wr_stb;

  // Next-state view of sync and error, feeding status_o and the error-driven init pin, echo and crc_error_o outputs
  assign sync_next = state_next == ST_SYNC || state_next == ST_ERR1 ||
                     state_next == ST_RELOAD;
  assign err_next  = state_next == ST_ERR1 || state_next == ST_ERR ||
                     state_next == ST_RELOAD;

  ////////////////////////////////////////////////////////////////////
  // Pin input passes two flops
  prsm_sync2 #(.W(1)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (ext_done_i),
    .q_o   (ext_done_s)
  );

  prsm_frame_cnt #(.WORDS(`PRSM_FRAME_WORDS)) u_frames (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .word_i       (cmd_reg[`PRSM_CMD_FRAME]),
    .abort_i      (abort_reg),
    .frame_done_o (frame_done),
    .frames_o     (frames)
  );

  // Upper status nibble from sync and error state
  function [3:0] hi_nibble;
    input sync;
    input err;
    begin
      case ({sync, err})
        2'b00:   hi_nibble = `PRSM_HI_IDLE;
        2'b10:   hi_nibble = `PRSM_HI_SYNC;
        2'b11:   hi_nibble = `PRSM_HI_SYNC_ERR;
        default: hi_nibble = `PRSM_HI_ERR;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, dropped next cycle
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o               <= 1'b0;
      dat_o               <= 32'h0000_0000;
      new_family_reg      <= 1'b0;
      readback_active_reg <= 1'b0;
      abort_reg           <= 1'b0;
      cmd_reg             <= 7'h00;
    end else begin
      ack_o   <= cyc_i && stb_i && !ack_o;
      cmd_reg <= 7'h00;
      if (wr_stb && adr_i == `PRSM_ADR_CTRL) begin
        new_family_reg      <= dat_i[`PRSM_CTRL_NEWFAM];
        readback_active_reg <= dat_i[`PRSM_CTRL_READBACK];
        abort_reg           <= dat_i[`PRSM_CTRL_ABORT];
      end
      // Command register is write-one pulse; holds nothing
      if (wr_stb && adr_i == `PRSM_ADR_CMD)
        cmd_reg <= dat_i[6:0];
      // Unmapped reads return zero
      case (adr_i)
        `PRSM_ADR_CTRL:   dat_o <= {29'h0, abort_reg, readback_active_reg,
                                    new_family_reg};
        `PRSM_ADR_STAT:   dat_o <= {22'h0, full_done_reg, seg_err_reg,
                                    status_o[7:1], cfg_err_reg}; // [R21]
        `PRSM_ADR_PORT:   dat_o <= status_o;
        `PRSM_ADR_FRAMES: dat_o <= {16'h0, frames};
        default:          dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sync/error sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (cmd_reg[`PRSM_CMD_SYNC])
          state_next = ST_SYNC; // [R8]
      ST_SYNC:
        if (cmd_reg[`PRSM_CMD_CRC_ERR])
          state_next = ST_ERR1; // [R9]
        else if (cmd_reg[`PRSM_CMD_RELEASE])
          state_next = ST_IDLE; // [R13]
      ST_ERR1:
        state_next = ST_ERR; // [R9]
      ST_ERR:
        if (cmd_reg[`PRSM_CMD_SYNC])
          state_next = ST_RELOAD; // [R12]
      // Synced with error held until reset-CRC
      ST_RELOAD:
        state_next = ST_RELOAD; // [R12]
      default:
        state_next = ST_IDLE;
    endcase
    // Reset-CRC clears error from any error state; back to sync if aligned, else idle
    if ((state_reg == ST_ERR1 || state_reg == ST_ERR || state_reg == ST_RELOAD) &&
        cmd_reg[`PRSM_CMD_RESET_CRC_COMMAND])
      state_next = sync_aligned_reg ? ST_SYNC : ST_IDLE; // [R11] [R12]
  end

  // Registered state flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg        <= ST_IDLE;
      sync_aligned_reg <= 1'b0;
      cfg_err_reg      <= 1'b0;
      pulse_reg        <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Sync held from sync word until release or error drop
      if (cmd_reg[`PRSM_CMD_SYNC])
        sync_aligned_reg <= 1'b1; // [R3]
      else if (state_next == ST_ERR || state_next == ST_IDLE)
        sync_aligned_reg <= 1'b0;
      // Error wins over a simultaneous clear
      if (cmd_reg[`PRSM_CMD_CRC_ERR] && state_reg == ST_SYNC)
        cfg_err_reg <= 1'b1; // [R2]
      else if (cmd_reg[`PRSM_CMD_RESET_CRC_COMMAND])
        cfg_err_reg <= 1'b0; // [R11]
      pulse_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs; status byte built from state, upper bits zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_o             <= {24'h0, `PRSM_HI_IDLE, `PRSM_LOW_OLD};
      init_status_n_o      <= 1'b1;
      init_status_oe_n_o   <= 1'b1;
      done_o               <= 1'b0;
      done_oe_n_o          <= 1'b0;
      partial_done_echo_o  <= 1'b0;
      partial_error_echo_o <= 1'b1;
      crc_error_o          <= 1'b0;
      full_done_reg        <= 1'b0;
      seg_err_reg          <= 1'b0;
    end else begin
      // Sync/error nibble; readback and abort overlay bits 5 and 4
      status_o <= {24'h0, // [R1]
                   (hi_nibble(sync_next, err_next)
                    | {2'b00, readback_active_reg, 1'b0}) // [R4] [R6]
                   & ~{3'b000, abort_reg}, // [R5]
                   new_family_reg ? `PRSM_LOW_NEW : `PRSM_LOW_OLD}; // [R7]
      // Open-drain pull-down while error held
      init_status_n_o    <= 1'b0;
      init_status_oe_n_o <= !err_next; // [R10]
      if (cmd_reg[`PRSM_CMD_FULLDONE])
        full_done_reg <= 1'b1; // [R20]
      done_o      <= full_done_reg || cmd_reg[`PRSM_CMD_FULLDONE];
      done_oe_n_o <= 1'b0;
      // Segment error flag resets at segment end or reset-CRC; echo follows error state
      if (cmd_reg[`PRSM_CMD_CRC_ERR] && state_reg == ST_SYNC)
        seg_err_reg <= 1'b1;
      else if (cmd_reg[`PRSM_CMD_SEG_END] || cmd_reg[`PRSM_CMD_RESET_CRC_COMMAND])
        seg_err_reg <= 1'b0;
      partial_error_echo_o <= !err_next; // [R16]
      partial_done_echo_o  <= ext_done_s && !frame_done; // [R14]
      crc_error_o          <= err_next; // [R21]
    end
  end
endmodule
`default_nettype wire

// ==== sim/prsm_ctl_model.sv ====
// Controller model: sticky CRC error and completion tracking
`timescale 1ns/1ps
`default_nettype none
module prsm_ctl_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic err_echo_i,
  input  wire logic end_of_startup_i,
  input  wire logic retry_i,
  output var  logic sticky_err_o,
  output var  logic load_done_o
);
  // Echo clears on reset-CRC, so hold our own copy until a retry
  always @(posedge clk_i) begin
    if (rst_i || retry_i)
      sticky_err_o <= 1'b0;
    else if (!err_echo_i)
      sticky_err_o <= 1'b1;
  end
  // Done echo may repeat across slices; trust end of startup
  always @(posedge clk_i) load_done_o <= !rst_i && end_of_startup_i;
  // No program or init pin is ever driven from here
endmodule
`default_nettype wire

// ==== sim/prsm_top_asserts.sv ====
// Port checks for the status monitor
`timescale 1ns/1ps
`default_nettype none
module prsm_top_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] status_o,
  input wire logic        init_status_n_o,
  input wire logic        init_status_oe_n_o,
  input wire logic        done_oe_n_o,
  input wire logic        partial_error_echo_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Synced, then the error shows up
  sequence s_err_hit;
    status_o[7:0] == 8'hDF ##1 status_o[7:0] == 8'h5F;
  endsequence
  a_upper_zero: assert property (status_o[31:8] == 24'h00_0000)
    else $error("status upper bits set");
  a_crc_seq: assert property (s_err_hit |=> status_o[7:0] == 8'h1F)
    else $error("error code not held after one cycle");
  a_err_first: assert property ($fell(status_o[7]) |-> status_o[7:0] == 8'h5F)
    else $error("error entry code wrong");
  a_ack_resp: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_low_nib: assert property (status_o[3:0] == 4'hF || status_o[3:0] == 4'hB)
    else $error("status low nibble wrong");
  a_pin_pull: assert property (!init_status_oe_n_o |-> !init_status_n_o)
    else $error("init pin enabled but not low");
  a_echo_pin: assert property (partial_error_echo_o == init_status_oe_n_o)
    else $error("error echo differs from init pin");
  a_done_drv: assert property (done_oe_n_o == 1'b0)
    else $error("done pin not driven");
endmodule
bind prsm_top prsm_top_asserts u_chk (.*);
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the status monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module tb;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic        ext_done_i = 0, end_of_startup = 0, retry = 0, sticky, ld_done;
  logic [3:0]  adr_i = 0, sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, status_o;
  logic        ack_o, init_status_n_o, init_status_oe_n_o, done_o, done_oe_n_o;
  logic        partial_done_echo_o, partial_error_echo_o, crc_error_o;
  int          err_total = 0, comparisons = 0, n;
  logic [31:0] exp_q[$];
  logic [31:0] exp_w;
  prsm_top DUT (.*);
  prsm_ctl_model u_ctl (.clk_i(clk_i), .rst_i(rst_i), .err_echo_i(partial_error_echo_o),
    .end_of_startup_i(end_of_startup), .retry_i(retry), .sticky_err_o(sticky), .load_done_o(ld_done));
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  // Read data pairs with the oldest queued expectation
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      `CHK(dat_o, exp_w)
    end
  // One classic cycle; random lanes always keep lane 0
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= {3'($urandom_range(7)), 1'b1};
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 40) err_total++;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the few microseconds the run needs
  initial begin
    #100_000;
    err_total++;
    final_report;
  end
  initial begin
    void'($urandom(81));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rd(4'h3, 32'h0000_009F);
    rd(4'h2, 32'h0000_009E);
    rd(4'hF, 32'h0000_0000);
    wr(4'hE, $urandom);
    wr(4'h1, 32'h0000_0001);
    rd(4'h3, 32'h0000_00DF);
    wr(4'h1, 32'h0000_0002);
    #1 `CHK(status_o, 32'h0000_005F)
    @(posedge clk_i);
    #1 `CHK(status_o, 32'h0000_001F)
    `CHK(init_status_oe_n_o, 1'b0)
    `CHK(partial_error_echo_o, 1'b0)
    `CHK(crc_error_o, 1'b1)
    `CHK(sticky, 1'b1)
    // Reload after the failure
    wr(4'h1, 32'h0000_0001);
    rd(4'h3, 32'h0000_005F);
    wr(4'h1, 32'h0000_0004);
    rd(4'h3, 32'h0000_00DF);
    `CHK(init_status_oe_n_o, 1'b1)
    retry <= 1;
    @(posedge clk_i);
    retry <= 0;
    // One word short of a frame commits nothing
    for (int i = 0; i < 92; i++) wr(4'h1, 32'h0000_0020);
    rd(4'h4, 32'h0000_0000);
    wr(4'h1, 32'h0000_0020);
    rd(4'h4, 32'h0000_0001);
    wr(4'h1, 32'h0000_0008);
    rd(4'h3, 32'h0000_009F);
    `CHK(sticky, 1'b0)
    wr(4'h1, 32'h0000_0010);
    ext_done_i <= 1;
    end_of_startup <= 1;
    #1 `CHK(done_o, 1'b1)
    n = 0;
    while (partial_done_echo_o !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(partial_done_echo_o, 1'b1)
    `CHK(ld_done, 1'b1)
    // Family, readback and abort combinations
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, i);
      rd(4'h0, i);
      rd(4'h3, {24'h00_0000, 2'b10, i[1], ~i[2], (i[0] ? 4'hB : 4'hF)});
    end
    @(posedge clk_i);
    final_report;
  end
endmodule
`default_nettype wire
